// *** common/eic_pkg.sv ***
// Constants, field layout and carrier types for the eight-source interrupt concentrator.
// Assumes a 20 MHz register-bus clock and a word-aligned register address.
package eic_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SRC  = 8;
    localparam int unsigned NUM_DAC  = 4;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 16;
    localparam int unsigned CNT_W    = 16;
    localparam int unsigned WORD_LSB = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 16'h2000;
    localparam logic [ADDR_W-1:0] OFS_PENDING = 16'h2004;
    localparam logic [ADDR_W-1:0] OFS_ENABLE  = 16'h2008;
    localparam logic [ADDR_W-1:0] OFS_ACK     = 16'h200C;
    localparam logic [ADDR_W-1:0] OFS_EN_SET  = 16'h2010;
    localparam logic [ADDR_W-1:0] OFS_EN_CLR  = 16'h2014;
    localparam logic [ADDR_W-1:0] OFS_CTL     = 16'h201C;

    // ------------------------------------------------------------------
    // Source bit positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_DAC0 = 0;
    localparam int unsigned BIT_DMA  = 4;
    localparam int unsigned BIT_ADC  = 5;
    localparam int unsigned BIT_CNT  = 6;
    localparam int unsigned BIT_DIO  = 7;

    // ------------------------------------------------------------------
    // Global control fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CTL_MASTER = 0;
    localparam int unsigned CTL_HW     = 1;
    localparam int unsigned CTL_W      = 2;

    localparam logic [NUM_SRC-1:0] RST_SRC  = 8'h00;
    localparam logic [CTL_W-1:0]   RST_CTL  = 2'h0;
    localparam logic [DATA_W-1:0]  RST_DATA = 32'h00000000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } eic_reg_req_s;

    typedef struct packed {
        logic [NUM_DAC-1:0] dac_burst_done;
        logic [NUM_DAC-1:0] dac_half_full;
        logic [NUM_DAC-1:0] dac_fifo_mode;
        logic               dma_done;
        logic               counter_req;
        logic               digital_req;
        logic [CNT_W-1:0]   adc_count;
        logic [CNT_W-1:0]   adc_threshold;
    } eic_src_s;

    // Word address match
    function automatic logic eic_addr_hit(input logic [ADDR_W-1:0] a,
                                          input logic [ADDR_W-1:0] ofs);
        return a[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB];
    endfunction : eic_addr_hit

endpackage : eic_pkg

// *** hw/eic_src.sv ***
// Request former: maps the peripheral requests onto the eight source bits.
// Assumes all request inputs are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module eic_src
    import eic_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    input  wire logic               ce,
    input  wire eic_src_s           src,
    output var  logic [NUM_SRC-1:0] req
);

    // ------------------------------------------------------------------
    // Combined request vector
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] next_req;

    genvar g;
    generate
        for (g = 0; g < NUM_DAC; g++) begin : g_dac
            assign next_req[BIT_DAC0+g] = src.dac_fifo_mode[g] ? src.dac_half_full[g]
                                                               : src.dac_burst_done[g];
        end
    endgenerate

    assign next_req[BIT_DMA] = src.dma_done;
    assign next_req[BIT_ADC] = src.adc_count >= src.adc_threshold;
    assign next_req[BIT_CNT] = src.counter_req;
    assign next_req[BIT_DIO] = src.digital_req;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req <= RST_SRC;
        end else if (ce) begin
            req <= next_req;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_adc_threshold;
        @(posedge clk) disable iff (!rstn)
        ce |=> req[BIT_ADC] == ($past(src.adc_count) >= $past(src.adc_threshold));
    endproperty
    a_adc_threshold: assert property (p_adc_threshold) else $error("adc threshold request wrong");

    property p_dac_mode;
        @(posedge clk) disable iff (!rstn)
        ce |=> req[BIT_DAC0] == ($past(src.dac_fifo_mode[0]) ? $past(src.dac_half_full[0])
                                                           : $past(src.dac_burst_done[0]));
    endproperty
    a_dac_mode: assert property (p_dac_mode) else $error("dac request ignores mode");

endmodule : eic_src
`default_nettype wire

// *** hw/eic_top.sv ***
// Eight-source interrupt concentrator: status, pending, enable, acknowledge,
// atomic enable set/clear and global control, one registered interrupt output.
// Assumes a simple register port synchronous to CLK, one access per cycle.
`timescale 1ns/1ps
`default_nettype none
module eic_top
    import eic_pkg::*;
(
    input  wire logic               CLK,
    input  wire logic               RSTN,
    input  wire logic               CE,
    input  wire logic [ADDR_W-1:0]  REG_ADDR,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    input  wire logic [DATA_W-1:0]  REG_WDATA,
    output var  logic [DATA_W-1:0]  REG_RDATA,
    output var  logic               REG_RVALID,
    input  wire logic [NUM_DAC-1:0] DAC_BURST_DONE,
    input  wire logic [NUM_DAC-1:0] DAC_HALF_FULL,
    input  wire logic [NUM_DAC-1:0] DAC_FIFO_MODE,
    input  wire logic               DMA_DONE,
    input  wire logic [CNT_W-1:0]   ADC_FIFO_COUNT,
    input  wire logic [CNT_W-1:0]   ADC_FIFO_THRESHOLD,
    input  wire logic               COUNTER_REQ,
    input  wire logic               DIGITAL_REQ,
    output var  logic               IRQ
);

    // ------------------------------------------------------------------
    // Request packing
    // ------------------------------------------------------------------
    eic_reg_req_s       bus;
    eic_src_s           src;
    logic [NUM_SRC-1:0] req;

    assign bus.wr    = REG_WR;
    assign bus.rd    = REG_RD;
    assign bus.addr  = REG_ADDR;
    assign bus.wdata = REG_WDATA;

    assign src.dac_burst_done = DAC_BURST_DONE;
    assign src.dac_half_full  = DAC_HALF_FULL;
    assign src.dac_fifo_mode  = DAC_FIFO_MODE;
    assign src.dma_done       = DMA_DONE;
    assign src.counter_req    = COUNTER_REQ;
    assign src.digital_req    = DIGITAL_REQ;
    assign src.adc_count      = ADC_FIFO_COUNT;
    assign src.adc_threshold  = ADC_FIFO_THRESHOLD;

    eic_src u_src (
        .clk  (CLK),
        .rstn (RSTN),
        .ce   (CE),
        .src  (src),
        .req  (req)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic wr_status;
    logic wr_enable;
    logic wr_ack;
    logic wr_en_set;
    logic wr_en_clr;
    logic wr_ctl;

    assign wr_status = bus.wr && eic_addr_hit(bus.addr, OFS_STATUS);
    assign wr_enable = bus.wr && eic_addr_hit(bus.addr, OFS_ENABLE);
    assign wr_ack    = bus.wr && eic_addr_hit(bus.addr, OFS_ACK);
    assign wr_en_set = bus.wr && eic_addr_hit(bus.addr, OFS_EN_SET);
    assign wr_en_clr = bus.wr && eic_addr_hit(bus.addr, OFS_EN_CLR);
    assign wr_ctl    = bus.wr && eic_addr_hit(bus.addr, OFS_CTL);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] status;
    logic [NUM_SRC-1:0] enable;
    logic               ctl_master;
    logic               ctl_hw;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] wbits;

    assign wbits   = bus.wdata[NUM_SRC-1:0];
    assign pending = status & enable;

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] hw_set;
    logic [NUM_SRC-1:0] sw_set;
    logic [NUM_SRC-1:0] ack_clr;
    logic [NUM_SRC-1:0] held;
    logic [NUM_SRC-1:0] next_status;

    assign hw_set  = ctl_hw ? req : RST_SRC;
    assign sw_set  = (wr_status && !ctl_hw) ? wbits : RST_SRC;
    assign ack_clr = wr_ack ? wbits : RST_SRC;
    assign held    = status & ~ack_clr;

    // Set wins over a clear in the same cycle
    assign next_status = held | hw_set | sw_set;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            status <= RST_SRC;
        end else if (CE) begin
            status <= next_status;
        end
    end

    // ------------------------------------------------------------------
    // Enable
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0] next_enable;

    always_comb begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable = wbits;
        end
        if (wr_en_set) begin
            next_enable = next_enable | wbits;
        end
        if (wr_en_clr) begin
            next_enable = next_enable & ~wbits;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            enable <= RST_SRC;
        end else if (CE) begin
            enable <= next_enable;
        end
    end

    // ------------------------------------------------------------------
    // Global control
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_master <= RST_CTL[CTL_MASTER];
        end else if (CE && wr_ctl) begin
            ctl_master <= bus.wdata[CTL_MASTER];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_hw <= RST_CTL[CTL_HW];
        end else if (CE && wr_ctl) begin
            ctl_hw <= ctl_hw | bus.wdata[CTL_HW];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    logic irq_any;
    logic next_irq;

    assign irq_any  = |pending;
    assign next_irq = irq_any && ctl_master;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else if (CE) begin
            IRQ <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] next_rdata;

    always_comb begin
        next_rdata = RST_DATA;
        if (eic_addr_hit(bus.addr, OFS_STATUS)) begin
            next_rdata[NUM_SRC-1:0] = status;
        end else if (eic_addr_hit(bus.addr, OFS_PENDING)) begin
            next_rdata[NUM_SRC-1:0] = pending;
        end else if (eic_addr_hit(bus.addr, OFS_ENABLE)) begin
            next_rdata[NUM_SRC-1:0] = enable;
        end else if (eic_addr_hit(bus.addr, OFS_CTL)) begin
            next_rdata[CTL_MASTER] = ctl_master;
            next_rdata[CTL_HW]     = ctl_hw;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= RST_DATA;
        end else if (CE && bus.rd) begin
            REG_RDATA <= next_rdata;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RVALID <= 1'b0;
        end else if (CE) begin
            REG_RVALID <= bus.rd;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_sw_write;
        CE && wr_status && !ctl_hw;
    endsequence

    sequence s_read_pending;
        CE && bus.rd && eic_addr_hit(bus.addr, OFS_PENDING);
    endsequence

    sequence s_read_ctl;
        CE && bus.rd && eic_addr_hit(bus.addr, OFS_CTL);
    endsequence

    sequence s_read_status;
        CE && bus.rd && eic_addr_hit(bus.addr, OFS_STATUS);
    endsequence

    sequence s_read_ack;
        CE && bus.rd && eic_addr_hit(bus.addr, OFS_ACK);
    endsequence

    property p_sw_write_sets;
        @(posedge CLK) disable iff (!RSTN)
        s_sw_write |=> (status & $past(wbits)) == $past(wbits);
    endproperty
    a_sw_write_sets: assert property (p_sw_write_sets) else $error("test write did not set");

    property p_sw_write_locked;
        @(posedge CLK) disable iff (!RSTN)
        CE && wr_status && ctl_hw && (req == RST_SRC) |=> status == $past(status);
    endproperty
    a_sw_write_locked: assert property (p_sw_write_locked) else $error("locked status changed");

    property p_hw_ignored;
        @(posedge CLK) disable iff (!RSTN)
        CE && !ctl_hw && !wr_status && !wr_ack |=> status == $past(status);
    endproperty
    a_hw_ignored: assert property (p_hw_ignored) else $error("hw input seen before enable");

    property p_masked_held;
        @(posedge CLK) disable iff (!RSTN)
        CE && !wr_ack |=> ($past(status & ~enable) & ~status) == RST_SRC;
    endproperty
    a_masked_held: assert property (p_masked_held) else $error("masked status lost");

    property p_ack_clears;
        @(posedge CLK) disable iff (!RSTN)
        CE && wr_ack && ctl_hw && ((req & wbits) == RST_SRC)
            |=> (status & $past(wbits)) == RST_SRC;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("acknowledge did not clear");

    property p_en_set;
        @(posedge CLK) disable iff (!RSTN)
        CE && wr_en_set |=> enable == ($past(enable) | $past(wbits));
    endproperty
    a_en_set: assert property (p_en_set) else $error("set enable wrong");

    property p_en_clr;
        @(posedge CLK) disable iff (!RSTN)
        CE && wr_en_clr |=> enable == ($past(enable) & ~$past(wbits));
    endproperty
    a_en_clr: assert property (p_en_clr) else $error("clear enable wrong");

    property p_master_gate;
        @(posedge CLK) disable iff (!RSTN)
        CE && !ctl_master |=> !IRQ;
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("irq without master");

    property p_unmask_irq;
        @(posedge CLK) disable iff (!RSTN)
        CE && ctl_master && (status[BIT_CNT] && enable[BIT_CNT]) |=> IRQ;
    endproperty
    a_unmask_irq: assert property (p_unmask_irq) else $error("unmasked irq missing");

    property p_irq_form;
        @(posedge CLK) disable iff (!RSTN)
        CE |=> IRQ == ($past(|pending) && $past(ctl_master));
    endproperty
    a_irq_form: assert property (p_irq_form) else $error("irq not or of pending");

    property p_hw_lock;
        @(posedge CLK) disable iff (!RSTN)
        ctl_hw |=> ctl_hw [*2];
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("hardware enable unlocked");

    property p_read_pending;
        @(posedge CLK) disable iff (!RSTN)
        s_read_pending |=> REG_RVALID &&
            REG_RDATA == {{(DATA_W-NUM_SRC){1'b0}}, $past(status & enable)};
    endproperty
    a_read_pending: assert property (p_read_pending) else $error("pending read wrong");

    property p_read_ctl;
        @(posedge CLK) disable iff (!RSTN)
        s_read_ctl |=> REG_RVALID &&
            REG_RDATA == {{(DATA_W-CTL_W){1'b0}}, $past(ctl_hw), $past(ctl_master)};
    endproperty
    a_read_ctl: assert property (p_read_ctl) else $error("control read wrong");

    property p_read_status;
        @(posedge CLK) disable iff (!RSTN)
        s_read_status |=> REG_RVALID &&
            REG_RDATA == {{(DATA_W-NUM_SRC){1'b0}}, $past(status)};
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_ack_no_store;
        @(posedge CLK) disable iff (!RSTN)
        s_read_ack |=> REG_RVALID && REG_RDATA == RST_DATA;
    endproperty
    a_ack_no_store: assert property (p_ack_no_store) else $error("ack read nonzero");

    property p_en_load;
        @(posedge CLK) disable iff (!RSTN)
        CE && wr_enable |=> enable == $past(wbits);
    endproperty
    a_en_load: assert property (p_en_load) else $error("enable load wrong");

    property p_hw_capture;
        @(posedge CLK) disable iff (!RSTN)
        CE && ctl_hw && (req != RST_SRC) |=> (status & $past(req)) == $past(req);
    endproperty
    a_hw_capture: assert property (p_hw_capture) else $error("hw request not captured");

endmodule : eic_top
`default_nettype wire

// *** verification/eic_host.sv ***
// Host register master model for the interrupt concentrator.
// Assumes the bench supplies CLK; strobes change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module eic_host
    import eic_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic [DATA_W-1:0] REG_RDATA,
    input  wire logic              REG_RVALID,
    output var  logic [ADDR_W-1:0] REG_ADDR,
    output var  logic              REG_WR,
    output var  logic              REG_RD,
    output var  logic [DATA_W-1:0] REG_WDATA
);
    // ------------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------------
    initial begin
        REG_ADDR  = 16'h0000;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = 32'h00000000;
    end

    // ------------------------------------------------------------------
    // Single write, one strobe cycle
    // ------------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge CLK);
        REG_ADDR  = a;
        REG_WDATA = d;
        REG_WR    = 1'b1;
        @(negedge CLK);
        REG_WR    = 1'b0;
        REG_ADDR  = ~a;
        REG_WDATA = ~d;
    endtask : wr

    // ------------------------------------------------------------------
    // Single read, data taken with the valid pulse
    // ------------------------------------------------------------------
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge CLK);
        REG_ADDR = a;
        REG_RD   = 1'b1;
        @(negedge CLK);
        REG_RD   = 1'b0;
        REG_ADDR = ~a;
        d        = (REG_RVALID === 1'b1) ? REG_RDATA : 32'hXXXXXXXX;
    endtask : rd
endmodule : eic_host
`default_nettype wire

// *** verification/eic_top_test.sv ***
// Self-checking bench for the interrupt concentrator.
// Assumes eic_top and the eic_host register master model.
`timescale 1ns/1ps
`default_nettype none
module eic_top_test
    import eic_pkg::*;
;
    logic              clk;
    logic              rstn;
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic [3:0]        dac_bd;
    logic [3:0]        dac_hf;
    logic              dma;
    logic [CNT_W-1:0]  adc_cnt;
    logic              ctr;
    logic              dig;
    logic              irq;
    logic              ce;
    logic [3:0]        mode;
    logic [CNT_W-1:0]  thr;
    logic [DATA_W-1:0] d;
    int                fails;
    int                total_checks;

    // ------------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------------
    initial clk = 1'b0;
    always #25 clk = ~clk;

    eic_top i_eic_top (.CLK(clk), .RSTN(rstn), .CE(ce), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .DAC_BURST_DONE(dac_bd), .DAC_HALF_FULL(dac_hf), .DAC_FIFO_MODE(mode),
        .DMA_DONE(dma), .ADC_FIFO_COUNT(adc_cnt), .ADC_FIFO_THRESHOLD(thr),
        .COUNTER_REQ(ctr), .DIGITAL_REQ(dig), .IRQ(irq));

    eic_host i_eic_host (.CLK(clk), .REG_RDATA(rdata), .REG_RVALID(rvalid), .REG_ADDR(addr),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic close_out();
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        i_eic_host.rd(a, d);
        total_checks++;
        if (d !== exp) begin
            fails++;
            $display("unexpected read at %0t: got %h want %h", $time, d, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic exp);
        total_checks++;
        if (irq !== exp) begin
            fails++;
            $display("unexpected irq at %0t: got %h want %h", $time, irq, exp);
        end
    endtask : chk_irq

    task automatic src(input logic [3:0] bd, input logic [3:0] hf, input logic dm,
                       input logic [CNT_W-1:0] cnt, input logic c, input logic g,
                       input logic [7:0] exp);
        @(negedge clk);
        dac_bd  = bd;
        dac_hf  = hf;
        dma     = dm;
        adc_cnt = cnt;
        ctr     = c;
        dig     = g;
        idle(3);
        dac_bd  = 4'h0;
        dac_hf  = 4'h0;
        dma     = 1'b0;
        adc_cnt = 16'h0000;
        ctr     = 1'b0;
        dig     = 1'b0;
        idle(2);
        chk_irq(exp != 8'h00);
        chk_reg(OFS_STATUS, {24'h000000, exp});
        i_eic_host.wr(OFS_ACK, 32'h000000FF);
    endtask : src

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        #(50 * 2000);
        fails++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        fails        = 0;
        total_checks = 0;
        rstn    = 1'b0;
        ce      = 1'b1;
        mode    = 4'hA;
        thr     = 16'h0005;
        dac_bd  = 4'h0;
        dac_hf  = 4'h0;
        dma     = 1'b0;
        adc_cnt = 16'h0000;
        ctr     = 1'b0;
        dig     = 1'b0;
        idle(6);
        rstn = 1'b1;
        chk_reg(OFS_ENABLE, 32'h00000000);
        chk_reg(OFS_CTL, 32'h00000000);
        chk_irq(1'b0);
        dma = 1'b1;
        idle(3);
        dma = 1'b0;
        chk_reg(OFS_STATUS, 32'h00000000);
        i_eic_host.wr(OFS_STATUS, 32'hFFFFFFA5);
        chk_reg(OFS_STATUS, 32'h000000A5);
        i_eic_host.wr(OFS_STATUS, 32'h00000002);
        chk_reg(OFS_STATUS, 32'h000000A7);
        chk_reg(OFS_PENDING, 32'h00000000);
        i_eic_host.wr(OFS_EN_SET, 32'h00000F03);
        chk_reg(OFS_ENABLE, 32'h00000003);
        i_eic_host.wr(OFS_EN_CLR, 32'h00000101);
        chk_reg(OFS_ENABLE, 32'h00000002);
        i_eic_host.wr(OFS_PENDING, 32'h000000FF);
        chk_reg(OFS_PENDING, 32'h00000002);
        chk_irq(1'b0);
        i_eic_host.wr(OFS_CTL, 32'hFFFFFFF1);
        idle(1);
        chk_irq(1'b1);
        chk_reg(OFS_CTL, 32'h00000001);
        i_eic_host.wr(OFS_CTL, 32'h00000000);
        idle(1);
        chk_irq(1'b0);
        i_eic_host.wr(OFS_CTL, 32'h00000001);
        i_eic_host.wr(OFS_EN_CLR, 32'h000000FF);
        idle(1);
        chk_irq(1'b0);
        chk_reg(OFS_STATUS, 32'h000000A7);
        i_eic_host.wr(OFS_EN_SET, 32'h00000001);
        idle(1);
        chk_irq(1'b1);
        i_eic_host.wr(OFS_ACK, 32'h00000000);
        chk_reg(OFS_STATUS, 32'h000000A7);
        i_eic_host.wr(OFS_ACK, 32'h00000109);
        idle(1);
        chk_irq(1'b0);
        chk_reg(OFS_STATUS, 32'h000000A6);
        chk_reg(OFS_ACK, 32'h00000000);
        chk_reg(16'h2018, 32'h00000000);
        i_eic_host.wr(OFS_ACK, 32'h000000FF);
        i_eic_host.wr(OFS_CTL, 32'h00000003);
        i_eic_host.wr(OFS_CTL, 32'h00000001);
        chk_reg(OFS_CTL, 32'h00000003);
        i_eic_host.wr(OFS_STATUS, 32'h00000008);
        chk_reg(OFS_STATUS, 32'h00000000);
        i_eic_host.wr(OFS_ENABLE, 32'h000000FF);
        src(4'hF, 4'h0, 1'b0, 16'h0000, 1'b0, 1'b0, 8'h05);
        src(4'h0, 4'hF, 1'b0, 16'h0000, 1'b0, 1'b0, 8'h0A);
        src(4'h0, 4'h0, 1'b1, 16'h0000, 1'b0, 1'b0, 8'h10);
        src(4'h0, 4'h0, 1'b0, 16'h0005, 1'b0, 1'b0, 8'h20);
        src(4'h0, 4'h0, 1'b0, 16'h0004, 1'b0, 1'b0, 8'h00);
        src(4'h0, 4'h0, 1'b0, 16'hFFFF, 1'b0, 1'b0, 8'h20);
        src(4'h0, 4'h0, 1'b0, 16'h0000, 1'b1, 1'b0, 8'h40);
        src(4'h0, 4'h0, 1'b0, 16'h0000, 1'b0, 1'b1, 8'h80);
        mode = 4'h5;
        thr  = 16'h0010;
        src(4'h3, 4'hC, 1'b0, 16'h000F, 1'b0, 1'b0, 8'h06);
        src(4'h0, 4'h0, 1'b0, 16'h0010, 1'b0, 1'b0, 8'h20);
        ce  = 1'b0;
        dig = 1'b1;
        i_eic_host.wr(OFS_EN_CLR, 32'h000000FF);
        dig = 1'b0;
        ce  = 1'b1;
        chk_reg(OFS_ENABLE, 32'h000000FF);
        chk_reg(OFS_STATUS, 32'h00000000);
        rstn = 1'b0;
        idle(2);
        rstn = 1'b1;
        chk_irq(1'b0);
        chk_reg(OFS_CTL, 32'h00000000);
        chk_reg(OFS_ENABLE, 32'h00000000);
        close_out();
    end
endmodule : eic_top_test
`default_nettype wire
